// ==== verilog/eeprom_pkg.sv ====
package eeprom_pkg;

	localparam int         MEM_AW        = 16;
	localparam int         PAGE_AW       = 7;
	localparam int         FIFO_DEPTH    = 2;
	localparam logic [7:0] MEM_RESET_VAL = 8'hff;
	localparam logic [3:0] BIT_LAST      = 4'h7;
	localparam logic [1:0] PIN_IDLE      = 2'h3;
	// arbitrary value, not tied to any real maker
	localparam logic [3:0] DEV_TYPE_DFLT = 4'h5;

	localparam int CLK_PERIOD_NS       = 5;
	localparam int WRITE_CYCLE_TIME_NS = 5000000;
	localparam int WRITE_CYCLES        = WRITE_CYCLE_TIME_NS / CLK_PERIOD_NS;

	typedef enum logic [8:0] {
		ST_IDLE   = 9'h001,
		ST_RX     = 9'h002,
		ST_RXEND  = 9'h004,
		ST_ACK    = 9'h008,
		ST_TX     = 9'h010,
		ST_TXACK  = 9'h020,
		ST_TXWAIT = 9'h040,
		ST_DRAIN  = 9'h080,
		ST_BUSY   = 9'h100
	} state_t;

	typedef enum logic [1:0] {
		K_SEL  = 2'h0,
		K_AHI  = 2'h1,
		K_ALO  = 2'h2,
		K_DATA = 2'h3
	} kind_t;

endpackage

// ==== verilog/pin_evt_if.sv ====
`timescale 1ns/1ps
interface pin_evt_if;
	logic scl_rise;
	logic scl_fall;
	logic start;
	logic stop;
	logic sda;
	modport src (output scl_rise, output scl_fall, output start, output stop, output sda);
	modport dst (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface

// ==== verilog/pin_sampler.sv ====
`timescale 1ns/1ps
module pin_sampler (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic scl_pin,
	input  wire logic sda_pin,
	pin_evt_if.src    ev
);
	// bit 1 is the clock line, bit 0 the data line
	logic [1:0] s1_ff;
	logic [1:0] s2_ff;
	logic [1:0] s3_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_ff <= eeprom_pkg::PIN_IDLE;
			s2_ff <= eeprom_pkg::PIN_IDLE;
			s3_ff <= eeprom_pkg::PIN_IDLE;
		end else begin
			s1_ff <= {scl_pin, sda_pin};
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	assign ev.scl_rise = s2_ff[1] & ~s3_ff[1];
	assign ev.scl_fall = ~s2_ff[1] & s3_ff[1];
	assign ev.start    = s2_ff[1] & s3_ff[1] & s3_ff[0] & ~s2_ff[0];
	assign ev.stop     = s2_ff[1] & s3_ff[1] & ~s3_ff[0] & s2_ff[0];
	assign ev.sda      = s2_ff[0];
endmodule

// ==== verilog/byte_fifo2.sv ====
`timescale 1ns/1ps
module byte_fifo2 #(
	parameter int WIDTH = 8,
	parameter int DEPTH = eeprom_pkg::FIFO_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int PTRW = $clog2(DEPTH);
	localparam int CNTW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] buf_ff [DEPTH];
	logic [PTRW-1:0]  wp_ff;
	logic [PTRW-1:0]  rp_ff;
	logic [CNTW-1:0]  cnt_ff;
	logic [PTRW-1:0]  nxt_wp;
	logic [PTRW-1:0]  nxt_rp;
	logic [CNTW-1:0]  nxt_cnt;
	logic             do_wr;
	logic             do_rd;

	function automatic logic [PTRW-1:0] ptr_inc(input logic [PTRW-1:0] p);
		return (p == PTRW'(DEPTH - 1)) ? '0 : PTRW'(p + 1'b1);
	endfunction

	assign in_ready  = (cnt_ff != CNTW'(DEPTH));
	assign out_valid = (cnt_ff != '0);
	assign out_data  = buf_ff[rp_ff];

	always_comb begin
		do_wr   = in_valid & in_ready;
		do_rd   = out_valid & out_ready;
		nxt_wp  = do_wr ? ptr_inc(wp_ff) : wp_ff;
		nxt_rp  = do_rd ? ptr_inc(rp_ff) : rp_ff;
		nxt_cnt = CNTW'(cnt_ff + CNTW'(do_wr) - CNTW'(do_rd));
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp_ff  <= '0;
			rp_ff  <= '0;
			cnt_ff <= '0;
			for (int i = 0; i < DEPTH; i++) begin
				buf_ff[i] <= '0;
			end
		end else begin
			wp_ff  <= nxt_wp;
			rp_ff  <= nxt_rp;
			cnt_ff <= nxt_cnt;
			if (do_wr) begin
				buf_ff[wp_ff] <= in_data;
			end
		end
	end
endmodule

// ==== verilog/serial_eeprom_rw_engine.sv ====
`timescale 1ns/1ps
// Behaviour
// - answer select only when chip bits match
// - mismatch: release bus, stay silent, standby
// - sample data on clock rising edges
// - write select: take two acked address bytes
// - protect seen before address end blocks writes
// - address arrives high byte then low
// - write starts only on stop after data ack
// - finished write leaves counter after last byte
// - during write cycle: bus ignored, line released
// - single byte acked unless protected
// - one to 128 bytes within one row
// - page bytes bump only low seven bits
// - select ignored while busy, acked after
// - reads ignore the protect input
// - each output byte advances the counter
// - random read: dummy write, restart, read
// - bare read select reads current address
// - acked bytes keep streaming consecutive addresses
// - counter wraps from top to zero
// - no ack after byte: stop, standby
// - memory starts with every byte FFh
module serial_eeprom_rw_engine #(
	parameter int         MEM_AW       = eeprom_pkg::MEM_AW,
	parameter int         WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES,
	parameter logic [3:0] DEV_TYPE_ID  = eeprom_pkg::DEV_TYPE_DFLT
) (
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	input  wire logic scl_pin,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe,
	input  wire logic chip_addr_pin0,
	input  wire logic chip_addr_pin1,
	input  wire logic chip_addr_pin2,
	input  wire logic write_protect_input,
	output logic      write_busy
);
	localparam int PW         = eeprom_pkg::PAGE_AW;
	localparam int RW         = MEM_AW - PW;
	localparam int PAGE_BYTES = 1 << PW;
	localparam int MEM_BYTES  = 1 << MEM_AW;

	////////////////////////////////////////////////////////////////////////////////
	// pin sampling and word buffer

	pin_evt_if ev ();

	pin_sampler u_smp (
		.clk     (ref_clk),
		.rst     (sys_rst),
		.scl_pin (scl_pin),
		.sda_pin (sda_in),
		.ev      (ev)
	);

	eeprom_pkg::state_t st_ff;
	eeprom_pkg::state_t nxt_st;
	eeprom_pkg::kind_t  kind_ff;
	eeprom_pkg::kind_t  nxt_kind;
	logic [3:0]         cfg_s1_ff;
	logic [3:0]         cfg_s2_ff;
	logic [3:0]         bcnt_ff;
	logic [3:0]         nxt_bcnt;
	logic [7:0]         sr_ff;
	logic [7:0]         nxt_sr;
	logic [7:0]         ahi_ff;
	logic [7:0]         nxt_ahi;
	logic [MEM_AW-1:0]  addr_ff;
	logic [MEM_AW-1:0]  nxt_addr;
	logic [RW-1:0]      row_ff;
	logic [RW-1:0]      nxt_row;
	logic [PW-1:0]      page_ff;
	logic [PW-1:0]      nxt_page;
	logic [PW-1:0]      cidx_ff;
	logic [PW-1:0]      nxt_cidx;
	logic [31:0]        cnt_ff;
	logic [31:0]        nxt_cnt;
	logic               rd_ff;
	logic               nxt_rd;
	logic               wp_ff;
	logic               nxt_wp;
	logic               oe_ff;
	logic               nxt_oe;
	logic               busy_ff;
	logic               sda_out_ff;
	logic               push;
	logic               pop;
	logic               clr_lat;
	logic               fifo_in_rdy;
	logic               fifo_out_vld;
	logic               fifo_out_rdy;
	logic [7:0]         fifo_out_dat;
	logic               mem_we;
	logic [MEM_AW-1:0]  mem_wa;
	logic [7:0]         mem_wd;
	logic [7:0]         mem_rd;
	logic               sel_match;
	logic               in_slot;
	logic [7:0]         mem_ff [MEM_BYTES];
	logic [7:0]         lat_ff [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] lat_v_ff;
	logic               wr_pend_ff;

	// received data bytes wait here until the row latch takes them
	byte_fifo2 #(
		.WIDTH (8),
		.DEPTH (eeprom_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk       (ref_clk),
		.rst       (sys_rst),
		.in_valid  (push),
		.in_ready  (fifo_in_rdy),
		.in_data   (sr_ff),
		.out_valid (fifo_out_vld),
		.out_ready (fifo_out_rdy),
		.out_data  (fifo_out_dat)
	);

	function automatic logic [MEM_AW-1:0] addr_inc(input logic [MEM_AW-1:0] a);
		return MEM_AW'(a + 1'b1);
	endfunction

	assign sda_out      = sda_out_ff;
	assign sda_oe       = oe_ff;
	assign write_busy   = busy_ff;
	assign mem_rd       = mem_ff[addr_ff];
	assign fifo_out_rdy = (st_ff != eeprom_pkg::ST_BUSY);
	assign pop          = fifo_out_vld & fifo_out_rdy;
	assign sel_match    = (sr_ff[7:4] == DEV_TYPE_ID) && (sr_ff[3:1] == cfg_s2_ff[2:0]);
	assign in_slot      = (st_ff == eeprom_pkg::ST_RX) && (kind_ff == eeprom_pkg::K_DATA) && (bcnt_ff <= 4'h1);

	////////////////////////////////////////////////////////////////////////////////
	// command engine

	always_comb begin
		nxt_st   = st_ff;
		nxt_kind = kind_ff;
		nxt_bcnt = bcnt_ff;
		nxt_sr   = sr_ff;
		nxt_ahi  = ahi_ff;
		nxt_addr = addr_ff;
		nxt_row  = row_ff;
		nxt_page = pop ? PW'(page_ff + 1'b1) : page_ff;
		nxt_cidx = cidx_ff;
		nxt_cnt  = cnt_ff;
		nxt_rd   = rd_ff;
		nxt_wp   = wp_ff;
		nxt_oe   = oe_ff;
		push     = 1'b0;
		clr_lat  = 1'b0;
		mem_we   = 1'b0;
		mem_wa   = {row_ff, cidx_ff};
		mem_wd   = lat_ff[cidx_ff];
		// protect is watched from start until the low address byte is done
		if (st_ff != eeprom_pkg::ST_IDLE && kind_ff != eeprom_pkg::K_DATA) begin
			nxt_wp = wp_ff | cfg_s2_ff[3];
		end
		case (st_ff)
			eeprom_pkg::ST_IDLE: begin
				nxt_oe = 1'b0;
			end
			eeprom_pkg::ST_RX: begin
				if (ev.scl_rise) begin
					nxt_sr   = {sr_ff[6:0], ev.sda};
					nxt_bcnt = 4'(bcnt_ff + 1'b1);
					if (bcnt_ff == eeprom_pkg::BIT_LAST) begin
						nxt_st = eeprom_pkg::ST_RXEND;
					end
				end
			end
			eeprom_pkg::ST_RXEND: begin
				if (ev.scl_fall) begin
					case (kind_ff)
						eeprom_pkg::K_SEL: begin
							if (sel_match) begin
								nxt_rd = sr_ff[0];
								nxt_oe = 1'b1;
								nxt_st = eeprom_pkg::ST_ACK;
							end else begin
								nxt_st = eeprom_pkg::ST_IDLE;
							end
						end
						eeprom_pkg::K_AHI: begin
							nxt_ahi = sr_ff;
							nxt_oe  = 1'b1;
							nxt_st  = eeprom_pkg::ST_ACK;
						end
						eeprom_pkg::K_ALO: begin
							nxt_addr = MEM_AW'({ahi_ff, sr_ff});
							nxt_row  = nxt_addr[MEM_AW-1:PW];
							nxt_page = nxt_addr[PW-1:0];
							nxt_oe   = 1'b1;
							nxt_st   = eeprom_pkg::ST_ACK;
						end
						default: begin
							if (wp_ff) begin
								nxt_st   = eeprom_pkg::ST_RX;
								nxt_bcnt = 4'h0;
							end else if (fifo_in_rdy) begin
								push   = 1'b1;
								nxt_oe = 1'b1;
								nxt_st = eeprom_pkg::ST_ACK;
							end
						end
					endcase
				end
			end
			eeprom_pkg::ST_ACK: begin
				if (ev.scl_fall) begin
					nxt_bcnt = 4'h0;
					nxt_oe   = 1'b0;
					if (kind_ff == eeprom_pkg::K_SEL && rd_ff) begin
						nxt_sr   = mem_rd;
						nxt_oe   = ~mem_rd[7];
						nxt_addr = addr_inc(addr_ff);
						nxt_st   = eeprom_pkg::ST_TX;
					end else begin
						nxt_st   = eeprom_pkg::ST_RX;
						nxt_kind = (kind_ff == eeprom_pkg::K_SEL) ? eeprom_pkg::K_AHI :
							(kind_ff == eeprom_pkg::K_AHI) ? eeprom_pkg::K_ALO : eeprom_pkg::K_DATA;
					end
				end
			end
			eeprom_pkg::ST_TX: begin
				if (ev.scl_fall) begin
					if (bcnt_ff == eeprom_pkg::BIT_LAST) begin
						nxt_oe = 1'b0;
						nxt_st = eeprom_pkg::ST_TXACK;
					end else begin
						nxt_sr   = {sr_ff[6:0], 1'b0};
						nxt_oe   = ~sr_ff[6];
						nxt_bcnt = 4'(bcnt_ff + 1'b1);
					end
				end
			end
			eeprom_pkg::ST_TXACK: begin
				if (ev.scl_rise) begin
					if (!ev.sda) begin
						nxt_sr   = mem_rd;
						nxt_addr = addr_inc(addr_ff);
						nxt_st   = eeprom_pkg::ST_TXWAIT;
					end else begin
						nxt_st = eeprom_pkg::ST_IDLE;
					end
				end
			end
			eeprom_pkg::ST_TXWAIT: begin
				if (ev.scl_fall) begin
					nxt_oe   = ~sr_ff[7];
					nxt_bcnt = 4'h0;
					nxt_st   = eeprom_pkg::ST_TX;
				end
			end
			eeprom_pkg::ST_DRAIN: begin
				nxt_oe   = 1'b0;
				nxt_cidx = '0;
				nxt_cnt  = 32'(WRITE_CYCLES - 1);
				if (!fifo_out_vld) begin
					nxt_st = eeprom_pkg::ST_BUSY;
				end
			end
			eeprom_pkg::ST_BUSY: begin
				// one latch a cycle goes to the array; the bus is not looked at
				nxt_oe   = 1'b0;
				mem_we   = lat_v_ff[cidx_ff];
				nxt_cidx = PW'(cidx_ff + 1'b1);
				if (cnt_ff == 32'h0) begin
					nxt_st   = eeprom_pkg::ST_IDLE;
					nxt_addr = {row_ff, page_ff};
					clr_lat  = 1'b1;
				end else begin
					nxt_cnt = 32'(cnt_ff - 1'b1);
				end
			end
			default: begin
				nxt_st = eeprom_pkg::ST_IDLE;
				nxt_oe = 1'b0;
			end
		endcase
		if (st_ff != eeprom_pkg::ST_DRAIN && st_ff != eeprom_pkg::ST_BUSY) begin
			if (ev.start) begin
				nxt_st   = eeprom_pkg::ST_RX;
				nxt_kind = eeprom_pkg::K_SEL;
				nxt_bcnt = 4'h0;
				nxt_oe   = 1'b0;
				nxt_wp   = cfg_s2_ff[3];
				clr_lat  = 1'b1;
			end else if (ev.stop) begin
				nxt_oe = 1'b0;
				if (in_slot && wr_pend_ff) begin
					nxt_st = eeprom_pkg::ST_DRAIN;
				end else begin
					nxt_st  = eeprom_pkg::ST_IDLE;
					clr_lat = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			st_ff      <= eeprom_pkg::ST_IDLE;
			kind_ff    <= eeprom_pkg::K_SEL;
			cfg_s1_ff  <= 4'h0;
			cfg_s2_ff  <= 4'h0;
			bcnt_ff    <= 4'h0;
			sr_ff      <= 8'h00;
			ahi_ff     <= 8'h00;
			addr_ff    <= '0;
			row_ff     <= '0;
			page_ff    <= '0;
			cidx_ff    <= '0;
			cnt_ff     <= 32'h0;
			rd_ff      <= 1'b0;
			wp_ff      <= 1'b0;
			oe_ff      <= 1'b0;
			busy_ff    <= 1'b0;
			sda_out_ff <= 1'b0;
		end else begin
			st_ff      <= nxt_st;
			kind_ff    <= nxt_kind;
			cfg_s1_ff  <= {write_protect_input, chip_addr_pin2, chip_addr_pin1, chip_addr_pin0};
			cfg_s2_ff  <= cfg_s1_ff;
			bcnt_ff    <= nxt_bcnt;
			sr_ff      <= nxt_sr;
			ahi_ff     <= nxt_ahi;
			addr_ff    <= nxt_addr;
			row_ff     <= nxt_row;
			page_ff    <= nxt_page;
			cidx_ff    <= nxt_cidx;
			cnt_ff     <= nxt_cnt;
			rd_ff      <= nxt_rd;
			wp_ff      <= nxt_wp;
			oe_ff      <= nxt_oe;
			busy_ff    <= (nxt_st == eeprom_pkg::ST_DRAIN) || (nxt_st == eeprom_pkg::ST_BUSY);
			sda_out_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// row latches and array

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			lat_v_ff   <= '0;
			wr_pend_ff <= 1'b0;
			for (int i = 0; i < PAGE_BYTES; i++) begin
				lat_ff[i] <= eeprom_pkg::MEM_RESET_VAL;
			end
		end else if (clr_lat) begin
			lat_v_ff   <= '0;
			wr_pend_ff <= 1'b0;
		end else begin
			if (pop) begin
				lat_ff[page_ff]   <= fifo_out_dat;
				lat_v_ff[page_ff] <= 1'b1;
			end
			if (push) begin
				wr_pend_ff <= 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < MEM_BYTES; i++) begin
				mem_ff[i] <= eeprom_pkg::MEM_RESET_VAL;
			end
		end else if (mem_we) begin
			mem_ff[mem_wa] <= mem_wd;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	sequence s_sel_done;
		st_ff == eeprom_pkg::ST_RXEND && kind_ff == eeprom_pkg::K_SEL && ev.scl_fall;
	endsequence
	sequence s_stop_slot;
		in_slot && wr_pend_ff && ev.stop && !ev.start;
	endsequence
	sequence s_read_acked;
		st_ff == eeprom_pkg::ST_TXACK && ev.scl_rise && !ev.sda;
	endsequence

	a_sel_match: assert property (s_sel_done ##0 sel_match |=> st_ff == eeprom_pkg::ST_ACK && sda_oe)
		else $error("matching select not acked");
	a_sel_mismatch: assert property (s_sel_done ##0 !sel_match |=> st_ff == eeprom_pkg::ST_IDLE ##1 !sda_oe)
		else $error("mismatching select not released");
	a_rx_sample: assert property (st_ff == eeprom_pkg::ST_RX && ev.scl_rise && !ev.start && !ev.stop
		|=> sr_ff[0] == $past(ev.sda))
		else $error("bit not taken on rising clock");
	a_wp_nack: assert property (st_ff == eeprom_pkg::ST_RXEND && kind_ff == eeprom_pkg::K_DATA && wp_ff
		&& ev.scl_fall |=> !sda_oe && !wr_pend_ff)
		else $error("protected data byte acked");
	a_write_start: assert property (s_stop_slot |=> st_ff == eeprom_pkg::ST_DRAIN ##1 write_busy)
		else $error("stop after data ack did not start write");
	a_stop_other: assert property (ev.stop && !ev.start && !in_slot && !write_busy |=> st_ff == eeprom_pkg::ST_IDLE)
		else $error("stop outside slot started write");
	a_busy_quiet: assert property (st_ff == eeprom_pkg::ST_BUSY && cnt_ff != 32'h0
		|=> st_ff == eeprom_pkg::ST_BUSY && !sda_oe && write_busy)
		else $error("bus touched during write cycle");
	a_commit_addr: assert property (st_ff == eeprom_pkg::ST_BUSY && cnt_ff == 32'h0
		|=> addr_ff == {$past(row_ff), $past(page_ff)} && !write_busy)
		else $error("counter wrong after write cycle");
	a_page_wrap: assert property (pop && st_ff != eeprom_pkg::ST_RXEND
		|=> page_ff == PW'($past(page_ff) + 1'b1) && $stable(row_ff))
		else $error("page pointer left its row");
	a_read_incr: assert property (s_read_acked |=> addr_ff == addr_inc($past(addr_ff)) ##1 st_ff == eeprom_pkg::ST_TXWAIT)
		else $error("read did not advance counter");
	a_nack_stop: assert property (st_ff == eeprom_pkg::ST_TXACK && ev.scl_rise && ev.sda && !ev.start && !ev.stop
		|=> st_ff == eeprom_pkg::ST_IDLE && !sda_oe)
		else $error("transmit kept after master nack");
endmodule

// ==== verif/i2c_master_model.sv ====
`timescale 1ns/1ps
module i2c_master_model (
	input  wire logic clk,
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda_line
);
	// a 125 ns bus bit is 25 clocks: quarters of 6, 6, 6 and 7
	localparam int QTR = 6;

	// bus idles with scl high and sda released to the pull-up
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	////////////////////////////////////////////////////////////
	// every pin change lands just after a clock edge
	task automatic qwait(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic bit_xfer(input logic v, output logic got);
		qwait(QTR);
		sda_low = ~v;
		qwait(QTR);
		scl = 1'b1;
		qwait(QTR);
		got = sda_line;
		qwait(QTR + 1);
		scl = 1'b0;
	endtask

	// also serves as repeated start, entered with scl low
	task automatic start_cond();
		qwait(QTR);
		sda_low = 1'b0;
		qwait(QTR);
		scl = 1'b1;
		qwait(QTR);
		sda_low = 1'b1;
		qwait(QTR + 1);
		scl = 1'b0;
	endtask

	task automatic stop_cond();
		qwait(QTR);
		sda_low = 1'b1;
		qwait(QTR);
		scl = 1'b1;
		qwait(QTR);
		sda_low = 1'b0;
		qwait(QTR + 1);
	endtask

	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(b[i], g);
		end
		bit_xfer(1'b1, g);
		ack = ~g;
	endtask

	// ack low on the last byte lets the read end
	task automatic get_byte(input logic ack, output logic [7:0] b);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			bit_xfer(1'b1, b[i]);
		end
		bit_xfer(~ack, g);
	endtask
endmodule

// ==== verif/tb_serial_eeprom_rw_engine.sv ====
`timescale 1ns/1ps
module tb_serial_eeprom_rw_engine;
	localparam int         WR_CYC = 600;
	localparam int         LIMIT  = 60000;
	localparam logic [2:0] CHIP   = 3'h5;

	logic       ref_clk;
	logic       sys_rst;
	logic       scl;
	logic       m_low;
	logic       sda_line;
	logic       sda_out;
	logic       sda_oe;
	logic       wp;
	logic       write_busy;
	logic [2:0] chip;
	int         err_total = 0;
	int         compares  = 0;
	int         cycles    = 0;

	// open-drain data line with pull-up
	assign sda_line = ~((sda_oe & ~sda_out) | m_low);

	serial_eeprom_rw_engine #(.WRITE_CYCLES(WR_CYC)) u_dut (
		.ref_clk             (ref_clk),
		.sys_rst             (sys_rst),
		.scl_pin             (scl),
		.sda_in              (sda_line),
		.sda_out             (sda_out),
		.sda_oe              (sda_oe),
		.chip_addr_pin0      (chip[0]),
		.chip_addr_pin1      (chip[1]),
		.chip_addr_pin2      (chip[2]),
		.write_protect_input (wp),
		.write_busy          (write_busy)
	);

	i2c_master_model m (
		.clk      (ref_clk),
		.scl      (scl),
		.sda_low  (m_low),
		.sda_line (sda_line)
	);

	always #2.5 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			err_total++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////
	task automatic end_sim();
		if (err_total == 0 && compares > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [7:0] sel(input logic rw);
		return {eeprom_pkg::DEV_TYPE_DFLT, chip, rw};
	endfunction

	task automatic addr_phase(input logic [15:0] a);
		logic ak;
		m.start_cond();
		m.put_byte(sel(1'b0), ak);
		chk("select ack", 8'h01, {7'h0, ak});
		m.put_byte(a[15:8], ak);
		chk("addr hi ack", 8'h01, {7'h0, ak});
		m.put_byte(a[7:0], ak);
		chk("addr lo ack", 8'h01, {7'h0, ak});
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d0, input logic [7:0] d1, input int n,
			input logic exp_ack);
		logic ak;
		addr_phase(a);
		for (int i = 0; i < n; i++) begin
			m.put_byte((i == 0) ? d0 : d1, ak);
			chk("data ack", {7'h0, exp_ack}, {7'h0, ak});
		end
		m.stop_cond();
	endtask

	task automatic poll_done();
		logic ak;
		int   t0;
		@(posedge ref_clk);
		#1 chk("busy after stop", 8'h01, {7'h0, write_busy});
		t0 = cycles;
		m.start_cond();
		m.put_byte(sel(1'b0), ak);
		m.stop_cond();
		chk("poll while busy", 8'h00, {7'h0, ak});
		// busy spans one drain clock plus WR_CYC clocks, starting a few clocks before t0
		while (cycles < t0 + WR_CYC - 8) begin
			@(posedge ref_clk);
			#1;
		end
		chk("busy held", 8'h01, {7'h0, write_busy});
		repeat (8) @(posedge ref_clk);
		#1 chk("busy done", 8'h00, {7'h0, write_busy});
		m.start_cond();
		m.put_byte(sel(1'b0), ak);
		m.stop_cond();
		chk("poll ack", 8'h01, {7'h0, ak});
	endtask

	task automatic rd2(input logic [15:0] a, input logic [7:0] e0, input logic [7:0] e1);
		logic       ak;
		logic [7:0] b;
		addr_phase(a);
		m.start_cond();
		m.put_byte(sel(1'b1), ak);
		chk("read select ack", 8'h01, {7'h0, ak});
		m.get_byte(1'b1, b);
		chk("first read byte", e0, b);
		m.get_byte(1'b0, b);
		chk("next read byte", e1, b);
		m.stop_cond();
	endtask

	task automatic cur_rd(input logic [7:0] e);
		logic       ak;
		logic [7:0] b;
		m.start_cond();
		m.put_byte(sel(1'b1), ak);
		chk("current select ack", 8'h01, {7'h0, ak});
		m.get_byte(1'b0, b);
		chk("current read byte", e, b);
		m.stop_cond();
	endtask

	////////////////////////////////////////////////////////////
	task automatic t_byte_write();
		cur_rd(8'hff);
		wr(16'h0000, 8'h3c, 8'h00, 1, 1'b1);
		poll_done();
		cur_rd(8'hff);
		rd2(16'hffff, 8'hff, 8'h3c);
	endtask

	task automatic t_page_wrap();
		wr(16'h0100, 8'h5a, 8'h00, 1, 1'b1);
		poll_done();
		// the page ends exactly at its row end, so the counter rolls over to the row start
		wr(16'h017e, 8'ha1, 8'hb2, 2, 1'b1);
		poll_done();
		cur_rd(8'h5a);
		rd2(16'h017e, 8'ha1, 8'hb2);
	endtask

	task automatic t_protect();
		@(posedge ref_clk);
		#1 wp = 1'b1;
		wr(16'h0000, 8'h55, 8'h00, 1, 1'b0);
		repeat (20) @(posedge ref_clk);
		chk("busy when protected", 8'h00, {7'h0, write_busy});
		rd2(16'h0000, 8'h3c, 8'hff);
		@(posedge ref_clk);
		#1 wp = 1'b0;
	endtask

	task automatic t_bad_slot();
		logic ak;
		addr_phase(16'h0001);
		m.put_byte(8'h77, ak);
		chk("data ack", 8'h01, {7'h0, ak});
		repeat (3) m.bit_xfer(1'b0, ak);
		m.stop_cond();
		repeat (20) @(posedge ref_clk);
		chk("busy after late stop", 8'h00, {7'h0, write_busy});
		rd2(16'h0000, 8'h3c, 8'hff);
	endtask

	task automatic t_standby();
		logic       ak;
		logic [7:0] b;
		m.start_cond();
		m.put_byte({eeprom_pkg::DEV_TYPE_DFLT, ~chip, 1'b0}, ak);
		chk("foreign select nack", 8'h00, {7'h0, ak});
		m.put_byte(8'h00, ak);
		chk("silent after mismatch", 8'h00, {7'h0, ak});
		addr_phase(16'hffff);
		m.start_cond();
		m.put_byte(sel(1'b1), ak);
		chk("top select ack", 8'h01, {7'h0, ak});
		m.get_byte(1'b0, b);
		chk("top byte", 8'hff, b);
		// a device still sending would now show address 0, which holds 3c
		m.get_byte(1'b0, b);
		chk("released after nack", 8'hff, b);
		m.stop_cond();
		@(posedge ref_clk);
		#1 chip = ~CHIP;
		cur_rd(8'h3c);
	endtask

	initial begin
		ref_clk = 1'b0;
		sys_rst = 1'b1;
		wp = 1'b0;
		chip = CHIP;
		repeat (5) @(posedge ref_clk);
		#1 sys_rst = 1'b0;
		repeat (30) @(posedge ref_clk);
		t_byte_write();
		t_page_wrap();
		t_protect();
		t_bad_slot();
		t_standby();
		end_sim();
	end
endmodule
